// ### src/enet_dma_status_tx_control.sv
// Channel event status, interrupt mask and transmit DMA command and configuration logic.
// How it works
// - Byte collision counters wrapping set bits 12, 13.
// - Word counters wrapping set bits 14, 15.
// - Receive frame in host memory sets 16.
// - No receive descriptor drops frame, sets 17.
// - Receive error ack sets 18, late 19.
// - Receive descriptor fetch parity error sets 20.
// - Receive unload tag error sets 21.
// - Unowned descriptor before end of packet: 22.
// - Bit 23 mirrors unmasked management interface interrupt.
// - Frame loaded into transmit FIFO sets 24.
// - All posted frames loaded, none owned: 25.
// - Transmit error ack sets 26, late 27.
// - Transmit read parity error sets 28.
// - Transmit unload tag error sets 29.
// - Non-word I/O cycle: error ack, bit 30.
// - I/O write parity error sets bit 31.
// - Pending wakes transmit DMA, self-clears when the wake-up is taken.
// - Enable arms load; clearing stops after buffer.
// - Threshold words gate MAC start, max 1BF.
// - Paced mode delays bit 25 until FIFO empty.
// - Configuration resets to 0x3FE.
// - Status read clears all bits except 23.
// - Unmasked events interrupt; mask resets, skips 23.
`timescale 1ns/1ns
`include "enet_dma_params.svh"

module enet_dma_status_tx_control
  import enet_dma_pkg::*;
#(
  parameter int FIFO_AW = 10
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire pio_req_t           pio_req,
  output pio_rsp_t                pio_rsp_ff,
  input  wire logic               parity_check_en,
  input  wire logic [11:0]        mac_evt,
  input  wire mac_cnt_t           mac_cnt,
  input  wire dma_evt_t           dma_evt,
  input  wire tx_desc_t           tx_desc,
  input  wire logic               management_interface_event,
  input  wire logic               tx_wake_taken,
  input  wire logic               tx_buf_busy,
  input  wire logic               tx_buf_done,
  input  wire logic [FIFO_AW-1:0] txfifo_words,
  input  wire logic               txfifo_frame_loaded,
  input  wire logic               txfifo_empty,
  output logic                    irq_ff,
  output logic                    tx_wake_ff,
  output logic                    tx_run_ff,
  output logic                    xmit_go_ff
);

  // ========================================================================
  // Address and size decoding
  function automatic logic hit(input pio_req_t r, input logic [27:0] a);
    hit = r.sel && (r.addr == a) && (r.size == `SB_SIZE_WORD);
  endfunction

  logic        size_bad;
  logic        par_bad;
  logic        wr_ok;
  logic        rd_status;

  always_comb begin
    size_bad  = pio_req.sel && (pio_req.size != `SB_SIZE_WORD);
    par_bad   = pio_req.sel && pio_req.wr && parity_check_en && (^{pio_req.wdata, pio_req.wpar});
    wr_ok     = pio_req.wr && !par_bad;
    rd_status = hit(pio_req, `ADDR_STATUS) && !pio_req.wr;
  end

  // ========================================================================
  // Registers written by software
  logic [10:0] cfg_ff;
  logic [31:0] mask_ff;
  logic        pend_ff;
  logic [31:0] status_ff;
  tx_state_t   state_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff <= `CFG_RESET;
    end else if (hit(pio_req, `ADDR_TX_CFG) && wr_ok) begin
      cfg_ff <= pio_req.wdata[10:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_ff <= `MASK_RESET;
    end else if (hit(pio_req, `ADDR_MASK) && wr_ok) begin
      mask_ff <= pio_req.wdata;
    end
  end

  // A new write of 1 wins over the acknowledge in the same cycle, so a packet
  // posted while the previous wake-up is being taken is never lost.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (hit(pio_req, `ADDR_TX_PEND) && wr_ok && pio_req.wdata[0]) begin
      pend_ff <= 1'b1;
    end else if (tx_wake_taken) begin
      pend_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Programmed I/O answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      pio_rsp_ff <= '0;
    end else begin
      pio_rsp_ff.ack     <= pio_req.sel && !size_bad;
      pio_rsp_ff.err_ack <= size_bad;
      pio_rsp_ff.rdata   <= 32'h0000_0000;
      if (pio_req.sel && !pio_req.wr && !size_bad) begin
        if (pio_req.addr == `ADDR_STATUS) begin
          pio_rsp_ff.rdata <= status_ff;
        end else if (pio_req.addr == `ADDR_MASK) begin
          pio_rsp_ff.rdata <= mask_ff;
        end else if (pio_req.addr == `ADDR_TX_CFG) begin
          pio_rsp_ff.rdata <= {21'h0, cfg_ff};
        end else if (pio_req.addr == `ADDR_TX_PEND) begin
          pio_rsp_ff.rdata <= {31'h0, pend_ff};
        end
      end
    end
  end

  // ========================================================================
  // Counter rollover detection
  mac_cnt_t prev_cnt_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_cnt_ff <= '0;
    end else begin
      prev_cnt_ff <= mac_cnt;
    end
  end

  // ========================================================================
  // Frame tracking for transmit descriptors
  logic in_frame_ff;
  logic own_loss;

  always_comb begin
    own_loss = tx_desc.valid && !tx_desc.own && in_frame_ff;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_frame_ff <= 1'b0;
    end else if (tx_desc.valid) begin
      in_frame_ff <= tx_desc.own && !tx_desc.end_of_packet_flag;
    end
  end

  // ========================================================================
  // Paced mode holds the all-frames event until the FIFO drains
  logic tx_all_wait_ff;
  logic tx_all_set;

  always_comb begin
    tx_all_set = (dma_evt.tx_all && (!cfg_ff[`CFG_PACED_BIT] || txfifo_empty)) ||
                 (tx_all_wait_ff && txfifo_empty);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_all_wait_ff <= 1'b0;
    end else if (tx_all_set) begin
      tx_all_wait_ff <= 1'b0;
    end else if (dma_evt.tx_all && cfg_ff[`CFG_PACED_BIT]) begin
      tx_all_wait_ff <= 1'b1;
    end
  end

  // ========================================================================
  // Status register
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  always_comb begin
    set_vec = {20'h00000, mac_evt};
    set_vec[`ST_EXC_COL]     = prev_cnt_ff.exc_col == `WRAP8_TOP && mac_cnt.exc_col == 8'h00;
    set_vec[`ST_LATE_COL]    = prev_cnt_ff.late_col == `WRAP8_TOP && mac_cnt.late_col == 8'h00;
    set_vec[`ST_FIRST_COL]   = prev_cnt_ff.first_col == `WRAP16_TOP &&
                               mac_cnt.first_col == 16'h0000;
    set_vec[`ST_DEFER]       = prev_cnt_ff.defer == `WRAP16_TOP && mac_cnt.defer == 16'h0000;
    set_vec[`ST_RX_DONE]     = dma_evt.rx_done;
    set_vec[`ST_RX_NO_DESC]  = dma_evt.rx_no_desc;
    set_vec[`ST_RX_ERR_ACK]  = dma_evt.rx_err_ack;
    set_vec[`ST_RX_LATE_ERR] = dma_evt.rx_late_err;
    set_vec[`ST_RX_PAR_ERR]  = dma_evt.rx_par_err;
    set_vec[`ST_RX_TAG_ERR]  = dma_evt.rx_tag_err;
    set_vec[`ST_OWN_LOSS]    = own_loss;
    set_vec[`ST_MIF]         = 1'b0;
    set_vec[`ST_TX_DONE]     = dma_evt.tx_done;
    set_vec[`ST_TX_ALL]      = tx_all_set;
    set_vec[`ST_TX_ERR_ACK]  = dma_evt.tx_err_ack;
    set_vec[`ST_TX_LATE_ERR] = dma_evt.tx_late_err;
    set_vec[`ST_TX_PAR_ERR]  = dma_evt.tx_par_err;
    set_vec[`ST_TX_TAG_ERR]  = dma_evt.tx_tag_err;
    set_vec[`ST_SLV_ERR_ACK] = size_bad;
    set_vec[`ST_SLV_PAR_ERR] = par_bad;
    clr_vec = rd_status ? 32'hffffffff : 32'h00000000;
  end

  // Bit 23 is a live copy of the management interface request; it is cleared
  // at its source, so reading this register leaves it alone.
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_ff <= 32'h00000000;
    end else begin
      status_ff              <= (status_ff & ~clr_vec) | set_vec;
      status_ff[`ST_MIF]     <= management_interface_event;
    end
  end

  // ========================================================================
  // Interrupt request
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & ~mask_ff & ~(32'h1 << `ST_MIF)) || status_ff[`ST_MIF];
    end
  end

  // ========================================================================
  // Transmit load control
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= TX_IDLE;
    end else begin
      case (state_ff)
        TX_IDLE: begin
          if (cfg_ff[`CFG_EN_BIT] && pend_ff) begin
            state_ff <= TX_ACTIVE;
          end
        end
        TX_ACTIVE: begin
          if (!cfg_ff[`CFG_EN_BIT]) begin
            state_ff <= tx_buf_busy ? TX_STOPPING : TX_IDLE;
          end else if (dma_evt.tx_all && !pend_ff) begin
            state_ff <= TX_IDLE;
          end
        end
        TX_STOPPING: begin
          if (tx_buf_done) begin
            state_ff <= TX_IDLE;
          end
        end
        default: begin
          state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_wake_ff <= 1'b0;
      tx_run_ff  <= 1'b0;
    end else begin
      tx_wake_ff <= pend_ff && cfg_ff[`CFG_EN_BIT] && !tx_wake_taken;
      tx_run_ff  <= state_ff != TX_IDLE;
    end
  end

  // A threshold above the limit means the whole frame is buffered first.
  logic [8:0] thr;

  always_comb begin
    thr = cfg_ff[`CFG_THR_MSB:`CFG_THR_LSB];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      xmit_go_ff <= 1'b0;
    end else if (thr > `THR_MAX) begin
      xmit_go_ff <= txfifo_frame_loaded;
    end else begin
      xmit_go_ff <= txfifo_frame_loaded ||
                    (txfifo_words >= FIFO_AW'(thr));
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_exc_col_wrap: assert property
    ((prev_cnt_ff.exc_col == 8'hff && mac_cnt.exc_col == 8'h00) |=> status_ff[12])
    else $error("excessive collision wrap not recorded");
  a_defer_wrap: assert property
    ((prev_cnt_ff.defer == 16'hffff && mac_cnt.defer == 16'h0000) |=> status_ff[15])
    else $error("defer timer wrap not recorded");
  a_rx_done_set: assert property (dma_evt.rx_done |=> status_ff[16])
    else $error("receive done not recorded");
  a_own_loss_set: assert property
    ((tx_desc.valid && tx_desc.own && !tx_desc.end_of_packet_flag) ##1
    (tx_desc.valid && !tx_desc.own) |=> status_ff[22])
    else $error("unowned descriptor inside frame not flagged");
  a_mif_mirror: assert property (management_interface_event |=> status_ff[23])
    else $error("management interface bit does not follow");
  a_size_err_ack: assert property
    (size_bad |=> pio_rsp_ff.err_ack && !pio_rsp_ff.ack && status_ff[30])
    else $error("non-word cycle not refused");
  a_pend_clear: assert property
    ((pend_ff && tx_wake_taken && !pio_req.sel) |=> !pend_ff)
    else $error("pending command did not self-clear");
  // Clearing the enable mid-buffer must keep load control running past the next cycle.
  a_stop_after_buf: assert property
    (($fell(cfg_ff[`CFG_EN_BIT]) && tx_buf_busy && state_ff == TX_ACTIVE && !tx_buf_done)
    |=> ##1 tx_run_ff)
    else $error("dma stopped before buffer end");
  a_paced_hold: assert property
    ((cfg_ff[10] && !txfifo_empty && dma_evt.tx_all && !tx_all_wait_ff)
    |=> !status_ff[25] || $past(status_ff[25]))
    else $error("paced mode raised all-frames early");
  a_status_rd_clr: assert property
    ((rd_status && set_vec == 32'h0)
    |=> status_ff[22:0] == 23'h0 && status_ff[31:24] == 8'h00)
    else $error("status read did not clear");
  a_irq_mask: assert property ((|(status_ff & ~mask_ff)) |=> irq_ff)
    else $error("unmasked event gave no interrupt");
  a_mif_irq: assert property (status_ff[23] |=> irq_ff)
    else $error("management interface event gave no interrupt");

  c_status_read: cover property (rd_status && status_ff[16]);
  c_wake_taken: cover property (tx_wake_ff ##1 tx_wake_taken);
  c_paced_release: cover property (tx_all_wait_ff ##1 status_ff[25]);
  c_threshold_go: cover property (!xmit_go_ff ##1 xmit_go_ff);

endmodule

// ### pkg/enet_dma_params.svh
// Register offsets, field positions, reset values and limits of the channel event and transmit DMA block.
`ifndef ENET_DMA_PARAMS_SVH
`define ENET_DMA_PARAMS_SVH

// ==========================================================================
// Register addresses
`define ADDR_TX_PEND      28'h8c02000
`define ADDR_TX_CFG       28'h8c02004
`define ADDR_STATUS       28'h8c00100
`define ADDR_MASK         28'h8c00104

// ==========================================================================
// Reset values
`define CFG_RESET         11'h3fe
`define MASK_RESET        32'hff7fffff

// ==========================================================================
// Transmit configuration fields
`define CFG_EN_BIT        0
`define CFG_THR_LSB       1
`define CFG_THR_MSB       9
`define CFG_PACED_BIT     10
`define THR_MAX           9'h1bf

// ==========================================================================
// Status bit positions
`define ST_EXC_COL        12
`define ST_LATE_COL       13
`define ST_FIRST_COL      14
`define ST_DEFER          15
`define ST_RX_DONE        16
`define ST_RX_NO_DESC     17
`define ST_RX_ERR_ACK     18
`define ST_RX_LATE_ERR    19
`define ST_RX_PAR_ERR     20
`define ST_RX_TAG_ERR     21
`define ST_OWN_LOSS       22
`define ST_MIF            23
`define ST_TX_DONE        24
`define ST_TX_ALL         25
`define ST_TX_ERR_ACK     26
`define ST_TX_LATE_ERR    27
`define ST_TX_PAR_ERR     28
`define ST_TX_TAG_ERR     29
`define ST_SLV_ERR_ACK    30
`define ST_SLV_PAR_ERR    31

// ==========================================================================
// Bus encodings and counter limits
`define SB_SIZE_WORD      3'h0
`define WRAP8_TOP         8'hff
`define WRAP16_TOP        16'hffff

`endif

// ### pkg/enet_dma_pkg.sv
// Types shared by the channel event and transmit DMA block.
package enet_dma_pkg;

  // ========================================================================
  // Programmed I/O request and answer
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [2:0]  size;
    logic [27:0] addr;
    logic [31:0] wdata;
    logic        wpar;
  } pio_req_t;

  typedef struct packed {
    logic        ack;
    logic        err_ack;
    logic [31:0] rdata;
  } pio_rsp_t;

  // ========================================================================
  // MAC counter values watched for rollover
  typedef struct packed {
    logic [7:0]  exc_col;
    logic [7:0]  late_col;
    logic [15:0] first_col;
    logic [15:0] defer;
  } mac_cnt_t;

  // ========================================================================
  // One-cycle events from the receive and transmit DMA engines
  typedef struct packed {
    logic rx_done;
    logic rx_no_desc;
    logic rx_err_ack;
    logic rx_late_err;
    logic rx_par_err;
    logic rx_tag_err;
    logic tx_done;
    logic tx_all;
    logic tx_err_ack;
    logic tx_late_err;
    logic tx_par_err;
    logic tx_tag_err;
  } dma_evt_t;

  // Descriptor fetched by transmit load control.
  typedef struct packed {
    logic valid;
    logic own;
    logic end_of_packet_flag;
  } tx_desc_t;

  typedef enum logic [1:0] {TX_IDLE, TX_ACTIVE, TX_STOPPING} tx_state_t;

endpackage

// ### sim/enet_far_side.sv
// Far-side model of the transmit DMA engine that accepts wake-ups.
`timescale 1ns/1ns

module enet_far_side (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tx_wake_ff,
  input  wire logic slow,
  output logic      tx_wake_taken
);
  logic [3:0] cnt_ff;
  logic       taken_ff;

  // =====================================================================
  // Wake-up acceptance
  // The slow setting holds the engine busy for several cycles, so the
  // pending bit can be seen standing before it self-clears.
  always_ff @(posedge mclk) begin
    if (rst || !tx_wake_ff || taken_ff) begin
      cnt_ff   <= 4'h0;
      taken_ff <= 1'b0;
    end else begin
      cnt_ff   <= cnt_ff + 4'h1;
      taken_ff <= (cnt_ff == (slow ? 4'h6 : 4'h0));
    end
  end

  assign tx_wake_taken = taken_ff;
endmodule

// ### sim/enet_dma_status_tx_control_tb_top.sv
// Self-checking bench for the channel event status and transmit DMA controls.
`timescale 1ns/1ns
`include "enet_dma_params.svh"

module enet_dma_status_tx_control_tb_top
  import enet_dma_pkg::*;
;
  typedef struct packed {
    logic [11:0] m;
    logic [11:0] d;
    logic [31:0] e;
  } row_t;

  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  pio_req_t   req  = '0;
  pio_rsp_t   rsp;
  pio_rsp_t   pio_rsp_ff;
  logic       par_en = 1'b0;
  logic [11:0] mac_evt = '0;
  mac_cnt_t   mac_cnt = '0;
  dma_evt_t   dma_evt = '0;
  tx_desc_t   tx_desc = '0;
  logic       mif_evt = 1'b0;
  logic       taken;
  logic       slow = 1'b0;
  logic       busy = 1'b0;
  logic       buf_done = 1'b0;
  logic [9:0] words = '0;
  logic       loaded = 1'b0;
  logic       empty = 1'b1;
  logic       irq_ff;
  logic       tx_wake_ff;
  logic       tx_run_ff;
  logic       xmit_go_ff;
  int         err_total = 0;
  int         checked = 0;
  row_t       rows [14];

  always #25 mclk = ~mclk;

  enet_dma_status_tx_control #(.FIFO_AW(10)) dut_u (
    .mclk(mclk), .rst(rst), .pio_req(req), .pio_rsp_ff(pio_rsp_ff),
    .parity_check_en(par_en), .mac_evt(mac_evt), .mac_cnt(mac_cnt),
    .dma_evt(dma_evt), .tx_desc(tx_desc), .management_interface_event(mif_evt),
    .tx_wake_taken(taken), .tx_buf_busy(busy), .tx_buf_done(buf_done),
    .txfifo_words(words), .txfifo_frame_loaded(loaded), .txfifo_empty(empty),
    .irq_ff(irq_ff), .tx_wake_ff(tx_wake_ff), .tx_run_ff(tx_run_ff),
    .xmit_go_ff(xmit_go_ff)
  );

  enet_far_side far_u (
    .mclk(mclk), .rst(rst), .tx_wake_ff(tx_wake_ff), .slow(slow),
    .tx_wake_taken(taken)
  );

  // =====================================================================
  // Shared tasks
  task automatic complete_run();
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  // One access: request stands one cycle, the answer is taken one edge later.
  task automatic pio(input logic w, input logic [2:0] sz, input logic [27:0] a,
                     input logic [31:0] d, input logic bad);
    @(posedge mclk);
    #5;
    req = '{1'b1, w, sz, a, d, (^d) ^ bad};
    @(posedge mclk);
    #1;
    rsp = pio_rsp_ff;
    #4;
    req.sel = 1'b0;
  endtask

  task automatic rd(input logic [27:0] a, input logic [31:0] e);
    pio(1'b0, `SB_SIZE_WORD, a, 32'h0, 1'b0);
    chk({rsp.ack, rsp.rdata}, {1'b1, e});
  endtask

  task automatic wr(input logic [27:0] a, input logic [31:0] d);
    pio(1'b1, `SB_SIZE_WORD, a, d, 1'b0);
  endtask

  task automatic wait_wake();
    for (int i = 0; i < 20 && tx_wake_ff !== 1'b1; i++) cyc(1);
  endtask

  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  initial begin
    rows = '{'{12'h001, 12'h000, 32'h00000001}, '{12'h800, 12'h000, 32'h00000800},
             '{12'h000, 12'h800, 32'h00010000}, '{12'h000, 12'h400, 32'h00020000},
             '{12'h000, 12'h200, 32'h00040000}, '{12'h000, 12'h100, 32'h00080000},
             '{12'h000, 12'h080, 32'h00100000}, '{12'h000, 12'h040, 32'h00200000},
             '{12'h000, 12'h020, 32'h01000000}, '{12'h000, 12'h010, 32'h02000000},
             '{12'h000, 12'h008, 32'h04000000}, '{12'h000, 12'h004, 32'h08000000},
             '{12'h000, 12'h002, 32'h10000000}, '{12'h000, 12'h001, 32'h20000000}};
    cyc(16);
    rst = 1'b0;
    rd(`ADDR_TX_CFG, 32'h3fe);
    rd(`ADDR_MASK, 32'hff7fffff);
    rd(`ADDR_STATUS, 32'h0);
    rd(`ADDR_TX_PEND, 32'h0);
    foreach (rows[i]) begin
      mac_evt = rows[i].m;
      dma_evt = rows[i].d;
      cyc(1);
      mac_evt = '0;
      dma_evt = '0;
      rd(`ADDR_STATUS, rows[i].e);
      rd(`ADDR_STATUS, 32'h0);
    end
    // A 16-bit counter passing 00ff to 0000 is no wrap.
    mac_cnt = '{8'hff, 8'hff, 16'h00ff, 16'hffff};
    cyc(1);
    mac_cnt = '0;
    rd(`ADDR_STATUS, 32'h0000b000);
    mac_cnt.first_col = 16'hffff;
    cyc(1);
    mac_cnt = '0;
    rd(`ADDR_STATUS, 32'h00004000);
    wr(`ADDR_MASK, 32'hfffeffff);
    dma_evt.rx_done = 1'b1;
    cyc(1);
    dma_evt = '0;
    cyc(2);
    chk(irq_ff, 1'b1);
    rd(`ADDR_STATUS, 32'h00010000);
    cyc(2);
    chk(irq_ff, 1'b0);
    wr(`ADDR_MASK, 32'hffffffff);
    mif_evt = 1'b1;
    cyc(3);
    chk(irq_ff, 1'b1);
    rd(`ADDR_STATUS, 32'h00800000);
    rd(`ADDR_STATUS, 32'h00800000);
    mif_evt = 1'b0;
    cyc(3);
    rd(`ADDR_STATUS, 32'h0);
    wr(`ADDR_MASK, 32'hff7fffff);
    pio(1'b0, 3'h2, `ADDR_STATUS, 32'h0, 1'b0);
    chk({rsp.ack, rsp.err_ack}, 2'b01);
    rd(`ADDR_STATUS, 32'h40000000);
    par_en = 1'b1;
    pio(1'b1, `SB_SIZE_WORD, `ADDR_TX_CFG, 32'h1, 1'b1);
    rd(`ADDR_TX_CFG, 32'h3fe);
    rd(`ADDR_STATUS, 32'h80000000);
    rd(28'h8c02f00, 32'h0);
    // Transmit: a prompt engine, then a slow one so the pending bit is seen.
    wr(`ADDR_TX_CFG, 32'h009);
    rd(`ADDR_TX_CFG, 32'h009);
    wr(`ADDR_TX_PEND, 32'h1);
    wait_wake();
    chk(tx_wake_ff, 1'b1);
    cyc(3);
    chk({tx_wake_ff, tx_run_ff}, 2'b01);
    slow = 1'b1;
    wr(`ADDR_TX_PEND, 32'h1);
    rd(`ADDR_TX_PEND, 32'h1);
    cyc(10);
    rd(`ADDR_TX_PEND, 32'h0);
    busy = 1'b1;
    wr(`ADDR_TX_CFG, 32'h008);
    cyc(2);
    chk(tx_run_ff, 1'b1);
    busy = 1'b0;
    buf_done = 1'b1;
    cyc(1);
    buf_done = 1'b0;
    cyc(2);
    chk(tx_run_ff, 1'b0);
    wr(`ADDR_TX_PEND, 32'h1);
    cyc(5);
    chk(tx_wake_ff, 1'b0);
    wr(`ADDR_TX_CFG, 32'h009);
    wait_wake();
    chk(tx_wake_ff, 1'b1);
    words = 10'h003;
    cyc(2);
    chk(xmit_go_ff, 1'b0);
    words = 10'h004;
    cyc(2);
    chk(xmit_go_ff, 1'b1);
    wr(`ADDR_TX_CFG, 32'h381);
    words = 10'h3ff;
    cyc(2);
    chk(xmit_go_ff, 1'b0);
    loaded = 1'b1;
    cyc(2);
    chk(xmit_go_ff, 1'b1);
    loaded = 1'b0;
    wr(`ADDR_TX_CFG, 32'h77f);
    words = 10'h1bf;
    cyc(2);
    chk(xmit_go_ff, 1'b1);
    rd(`ADDR_STATUS, 32'h0);
    empty = 1'b0;
    dma_evt.tx_all = 1'b1;
    cyc(1);
    dma_evt = '0;
    rd(`ADDR_STATUS, 32'h0);
    empty = 1'b1;
    cyc(2);
    rd(`ADDR_STATUS, 32'h02000000);
    tx_desc = '{1'b1, 1'b1, 1'b0};
    cyc(1);
    tx_desc = '{1'b1, 1'b0, 1'b0};
    cyc(1);
    tx_desc = '0;
    cyc(1);
    rd(`ADDR_STATUS, 32'h00400000);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk({irq_ff, tx_wake_ff, tx_run_ff, xmit_go_ff}, 4'h0);
    rd(`ADDR_TX_CFG, 32'h3fe);
    rd(`ADDR_MASK, 32'hff7fffff);
    complete_run();
  end
endmodule
